// file: pack_protection_fet_fuse_ctrl.sv
// Decided for this implementation: the AHB-Lite register port.
`include "pack_prot_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module pack_protection_fet_fuse_ctrl
  import pack_prot_pkg::*;
#(
  parameter int unsigned FUSE_DELAY_CYC = `FUSE_DELAY_MS * 1000 * `SYS_CLK_MHZ,
  parameter int unsigned FUSE_BLOW_CYC = `FUSE_BLOW_MS * 1000 * `SYS_CLK_MHZ,
  parameter int unsigned RST_HOLD_CYC = `RST_HOLD_US * `SYS_CLK_MHZ,
  parameter int unsigned OSC_WINDOW_CYC = `OSC_WINDOW_US * `SYS_CLK_MHZ,
  parameter int unsigned OSC_MIN_EDGES = `OSC_NOM_HZ / 1000 * `OSC_WINDOW_US / 2000
) (
  input wire logic sys_clk, // 250 MHz clock
  input wire logic rst, // Async reset, active high
  input wire logic hsel, // AHB-Lite select
  input wire logic [31:0] haddr, // AHB-Lite address
  input wire logic [1:0] htrans, // AHB-Lite transfer type
  input wire logic hwrite, // AHB-Lite write
  input wire logic [2:0] hsize, // AHB-Lite size, word only
  input wire logic [31:0] hwdata, // AHB-Lite write data
  input wire logic hready, // AHB-Lite bus ready
  output logic hreadyout, // Always ready, no waits
  output logic hresp, // Always OKAY
  output word_t hrdata, // Read data, registered
  input wire logic safetyFault, // Pin: any safety fault
  input wire logic supplyAboveSense, // Pin: supply above high-side node
  input wire logic fuseDriveRaw, // Pin: fuse drive state
  input wire logic regulatorGood, // Pin: regulator above threshold+hys
  input wire logic slowOscIn, // Pin: 262.144 kHz oscillator
  input wire logic wakeCompTrip, // Pin: sense voltage past threshold
  input wire meas_t cellVoltMin, // Lowest cell voltage
  input wire meas_t cellVoltMax, // Highest cell voltage
  input wire meas_t chargeCurrent, // Measured charge current
  output logic chargeFetGate, // Charge FET gate drive
  output logic dischargeFetGate, // Discharge FET gate drive
  output logic adapterFetGate, // Adapter FET gate drive
  output logic [2:0] balanceEn, // Cell bypass switches
  output logic [7:0] wakeThreshold, // Wake comparator threshold
  output logic [7:0] trimValue, // Trim to the analog front end
  output logic gaugeResetOut, // Internal reset, high during hold
  output logic halted, // Halt state
  output logic frontEndIrq, // Interrupt, active high
  output meas_t chargeVoltSet, // Charger voltage target
  output meas_t chargeCurSet, // Charger current target
  output logic buckHighGate, // Buck high-side gate
  output logic buckLowGate // Buck low-side gate
);
  localparam int unsigned BUCK_PERIOD = `SYS_CLK_MHZ * 1000 / `BUCK_KHZ;

  // Synchronised pins
  logic safeS, supplyS, fuseS, regS, oscS, wakeS;
  level_sync #(.W(6)) pinSync (
    .sys_clk(sys_clk),
    .rst(rst),
    .asyncIn({safetyFault, supplyAboveSense, fuseDriveRaw, regulatorGood, slowOscIn,
      wakeCompTrip}),
    .syncOut({safeS, supplyS, fuseS, regS, oscS, wakeS})
  );

  logic oscFail;
  slow_osc_monitor #(.WINDOW_CYC(OSC_WINDOW_CYC), .MIN_EDGES(OSC_MIN_EDGES)) oscMon (
    .sys_clk(sys_clk),
    .rst(rst),
    .oscLevel(oscS),
    .oscFail(oscFail)
  );

  // Register index of a word address, and whether it is mapped
  function automatic logic [3:0] regIdx(input logic [31:0] a);
    regIdx = a[5:2];
  endfunction

  function automatic logic isMapped(input logic [31:0] a);
    isMapped = (a[31:6] == '0) && (a[5:2] <= `IDX_LAST);
  endfunction

  // Bus phase state
  logic wrPend_r, wrPend_nxt;
  logic [3:0] wrIdx_r, wrIdx_nxt;
  logic wrOk_r, wrOk_nxt;
  word_t hrdata_nxt;
  logic accept, latchRead;

  // Register file state
  logic [`CTL_W-1:0] ctl_r, ctl_nxt;
  logic acPermit_r, acPermit_nxt;
  logic [`LT_W-1:0] latch_r, latch_nxt;
  logic [2:0] bal_r, bal_nxt;
  logic [7:0] trim_r, trim_nxt;
  logic trimLoaded_r, trimLoaded_nxt;
  logic [7:0] wake_r, wake_nxt;
  word_t hostTgt_r, hostTgt_nxt;
  word_t storedTgt_r, storedTgt_nxt;
  word_t chgCfg_r, chgCfg_nxt;
  logic [7:0] duty_r, duty_nxt;
  logic halted_r, halted_nxt;
  logic irq_r, irq_nxt;
  logic [7:0] statusWord;
  logic [7:0] statusPrev_r;

  // Fuse, reset hold and gate state
  logic [31:0] fuseCnt_r, fuseCnt_nxt;
  logic [31:0] blowCnt_r, blowCnt_nxt;
  logic blowArmed_r, blowArmed_nxt;
  logic fuseCut_r, fuseCut_nxt;
  logic fuseSet;
  logic [31:0] holdCnt_r, holdCnt_nxt;
  logic resetHeld_r, resetHeld_nxt;
  logic fetAllowed;

  // Charger state
  charge_phase_t phase_r, phase_nxt;
  logic [7:0] buckCnt_r, buckCnt_nxt;
  meas_t voltSel, curSel;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign accept = hsel & htrans[1] & hready;
  assign latchRead = accept & ~hwrite & isMapped(haddr) & (regIdx(haddr) == `IDX_LATCH);

  // Live status byte; the raw fuse bit is always visible
  assign statusWord = {1'b0, phase_r, adapterFetGate, trimLoaded_r, halted_r,
    fuseS, acPermit_r};

  // Address phase capture and read data, registered for the data phase
  always_comb
  begin
    wrPend_nxt = accept & hwrite;
    wrIdx_nxt = regIdx(haddr);
    wrOk_nxt = isMapped(haddr);
    hrdata_nxt = hrdata;
    if (accept & ~hwrite)
    begin
      hrdata_nxt = '0;
      if (isMapped(haddr))
      begin
        unique case (regIdx(haddr))
          `IDX_CONTROL: hrdata_nxt = {27'h0, ctl_r};
          `IDX_STATUS: hrdata_nxt = {24'h0, statusWord};
          `IDX_LATCH: hrdata_nxt = {29'h0, latch_r};
          `IDX_BALANCE: hrdata_nxt = {29'h0, bal_r};
          `IDX_TRIM: hrdata_nxt = {24'h0, trim_r};
          `IDX_WAKE: hrdata_nxt = {24'h0, wake_r};
          `IDX_HOST_TGT: hrdata_nxt = hostTgt_r;
          `IDX_STORED_TGT: hrdata_nxt = storedTgt_r;
          `IDX_CHG_CFG: hrdata_nxt = chgCfg_r;
          default: hrdata_nxt = {24'h0, duty_r};
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wrPend_r <= 1'b0;
      wrIdx_r <= '0;
      wrOk_r <= 1'b0;
      hrdata <= '0;
    end
    else
    begin
      wrPend_r <= wrPend_nxt;
      wrIdx_r <= wrIdx_nxt;
      wrOk_r <= wrOk_nxt;
      hrdata <= hrdata_nxt;
    end
  end

  // Register writes, sticky flags, halt and interrupt
  always_comb
  begin
    ctl_nxt = ctl_r;
    acPermit_nxt = acPermit_r;
    latch_nxt = latch_r;
    bal_nxt = bal_r;
    trim_nxt = trim_r;
    trimLoaded_nxt = trimLoaded_r;
    wake_nxt = wake_r;
    hostTgt_nxt = hostTgt_r;
    storedTgt_nxt = storedTgt_r;
    chgCfg_nxt = chgCfg_r;
    duty_nxt = duty_r;
    halted_nxt = halted_r;
    irq_nxt = irq_r & ~latchRead;
    if (wrPend_r & wrOk_r)
    begin
      unique case (wrIdx_r)
        `IDX_CONTROL: ctl_nxt = hwdata[`CTL_W-1:0];
        `IDX_STATUS: acPermit_nxt = hwdata[`ST_ADAPTER_FET_PERMIT];
        `IDX_LATCH: latch_nxt = latch_r & ~hwdata[`LT_W-1:0];
        `IDX_BALANCE: bal_nxt = hwdata[2:0];
        `IDX_TRIM:
        begin
          trim_nxt = hwdata[7:0];
          trimLoaded_nxt = 1'b1;
        end
        `IDX_WAKE: wake_nxt = hwdata[7:0];
        `IDX_HOST_TGT: hostTgt_nxt = hwdata;
        `IDX_STORED_TGT: storedTgt_nxt = hwdata;
        `IDX_CHG_CFG: chgCfg_nxt = hwdata;
        default: duty_nxt = hwdata[7:0];
      endcase
    end
    // Halt request is a one-shot; wake beats a same-cycle request
    if (ctl_nxt[`CTL_HALT])
    begin
      halted_nxt = 1'b1;
      ctl_nxt[`CTL_HALT] = 1'b0;
    end
    if (wakeS)
      halted_nxt = 1'b0;
    // Hardware set wins over a software clear in the same cycle
    if (fuseSet)
      latch_nxt[`LT_FUSE] = 1'b1;
    if (oscFail)
      latch_nxt[`LT_OSC] = 1'b1;
    if (safeS)
      latch_nxt[`LT_SAFETY] = 1'b1;
    // Newly set flags or a changed status byte raise the interrupt
    if ((latch_nxt & ~latch_r) != '0 || statusWord != statusPrev_r)
      irq_nxt = 1'b1;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ctl_r <= `CTL_RESET;
      acPermit_r <= 1'b0;
      latch_r <= '0;
      bal_r <= `BAL_RESET;
      trim_r <= '0;
      trimLoaded_r <= 1'b0;
      wake_r <= `WAKE_RESET;
      hostTgt_r <= '0;
      storedTgt_r <= '0;
      chgCfg_r <= '0;
      duty_r <= `BUCK_RESET;
      halted_r <= 1'b0;
      irq_r <= 1'b0;
      statusPrev_r <= '0;
    end
    else
    begin
      ctl_r <= ctl_nxt;
      acPermit_r <= acPermit_nxt;
      latch_r <= latch_nxt;
      bal_r <= bal_nxt;
      trim_r <= trim_nxt;
      trimLoaded_r <= trimLoaded_nxt;
      wake_r <= wake_nxt;
      hostTgt_r <= hostTgt_nxt;
      storedTgt_r <= storedTgt_nxt;
      chgCfg_r <= chgCfg_nxt;
      duty_r <= duty_nxt;
      halted_r <= halted_nxt;
      irq_r <= irq_nxt;
      statusPrev_r <= statusWord;
    end
  end

  assign balanceEn = bal_r;
  assign wakeThreshold = wake_r;
  assign trimValue = trim_r;
  assign halted = halted_r;
  assign frontEndIrq = irq_r;

  // Fuse qualification then blow timer; a cut stays until reset
  always_comb
  begin
    fuseSet = 1'b0;
    fuseCnt_nxt = '0;
    blowArmed_nxt = blowArmed_r;
    blowCnt_nxt = blowCnt_r;
    fuseCut_nxt = fuseCut_r;
    if (fuseS)
    begin
      fuseCnt_nxt = fuseCnt_r;
      if (fuseCnt_r < FUSE_DELAY_CYC)
        fuseCnt_nxt = fuseCnt_r + 32'h1;
      if (fuseCnt_r == FUSE_DELAY_CYC - 1)
        fuseSet = 1'b1;
    end
    if (fuseSet)
    begin
      blowArmed_nxt = 1'b1;
      blowCnt_nxt = '0;
    end
    else if (blowArmed_r)
    begin
      // Software clearing the flag in time aborts the cut
      if (!latch_r[`LT_FUSE])
        blowArmed_nxt = 1'b0;
      else if (blowCnt_r == FUSE_BLOW_CYC - 1)
      begin
        fuseCut_nxt = 1'b1;
        blowArmed_nxt = 1'b0;
      end
      else
        blowCnt_nxt = blowCnt_r + 32'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      fuseCnt_r <= '0;
      blowCnt_r <= '0;
      blowArmed_r <= 1'b0;
      fuseCut_r <= 1'b0;
    end
    else
    begin
      fuseCnt_r <= fuseCnt_nxt;
      blowCnt_r <= blowCnt_nxt;
      blowArmed_r <= blowArmed_nxt;
      fuseCut_r <= fuseCut_nxt;
    end
  end

  // Reset hold: regulator must stay good for the whole hold time
  always_comb
  begin
    holdCnt_nxt = '0;
    resetHeld_nxt = 1'b1;
    if (regS)
    begin
      holdCnt_nxt = holdCnt_r;
      if (holdCnt_r < RST_HOLD_CYC)
        holdCnt_nxt = holdCnt_r + 32'h1;
      resetHeld_nxt = (holdCnt_nxt < RST_HOLD_CYC);
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      holdCnt_r <= '0;
      resetHeld_r <= 1'b1;
    end
    else
    begin
      holdCnt_r <= holdCnt_nxt;
      resetHeld_r <= resetHeld_nxt;
    end
  end

  assign gaugeResetOut = resetHeld_r;

  // Charge and discharge gates need trim loaded, no fault and no fuse cut
  assign fetAllowed = ~resetHeld_r & trimLoaded_r & ~safeS & ~fuseCut_r;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      chargeFetGate <= 1'b0;
      dischargeFetGate <= 1'b0;
      adapterFetGate <= 1'b0;
    end
    else
    begin
      chargeFetGate <= fetAllowed & ctl_r[`CTL_CHG_EN];
      dischargeFetGate <= fetAllowed & ctl_r[`CTL_DSG_EN];
      adapterFetGate <= acPermit_r & supplyS & ~resetHeld_r;
    end
  end

  // Target selection: host profile or stored profile
  assign voltSel = ctl_r[`CTL_HOST_PROF] ? hostTgt_r[15:0] : storedTgt_r[15:0];
  assign curSel = ctl_r[`CTL_HOST_PROF] ? hostTgt_r[31:16] : storedTgt_r[31:16];

  // Charge phases and 1 MHz buck counter
  always_comb
  begin
    phase_nxt = phase_r;
    buckCnt_nxt = 8'h0;
    if (buckCnt_r != BUCK_PERIOD[7:0] - 8'h1)
      buckCnt_nxt = buckCnt_r + 8'h1;
    if (!(ctl_r[`CTL_CHGR_EN] & fetAllowed & ~halted_r))
      phase_nxt = PH_IDLE;
    else
    begin
      unique case (phase_r)
        PH_IDLE: phase_nxt = (cellVoltMin < chgCfg_r[15:0]) ? PH_PRE : PH_CCCV;
        PH_PRE:
          if (cellVoltMin >= chgCfg_r[15:0])
            phase_nxt = PH_CCCV;
        PH_CCCV:
          if (cellVoltMax >= voltSel && chargeCurrent < chgCfg_r[31:16])
            phase_nxt = PH_DONE;
        PH_DONE: phase_nxt = PH_DONE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      phase_r <= PH_IDLE;
      buckCnt_r <= '0;
      chargeVoltSet <= '0;
      chargeCurSet <= '0;
      buckHighGate <= 1'b0;
      buckLowGate <= 1'b0;
    end
    else
    begin
      phase_r <= phase_nxt;
      buckCnt_r <= buckCnt_nxt;
      chargeVoltSet <= voltSel;
      // Precharge runs at a fraction of the full target current
      chargeCurSet <= (phase_r == PH_PRE) ? (curSel >> `PRE_CUR_SHIFT) : curSel;
      // Complementary drive; no dead time, the external driver adds it
      buckHighGate <= (phase_r == PH_PRE || phase_r == PH_CCCV) && (buckCnt_r < duty_r);
      buckLowGate <= (phase_r == PH_PRE || phase_r == PH_CCCV) && (buckCnt_r >= duty_r);
    end
  end
endmodule
`default_nettype wire

// file: pack_prot_consts.svh
`ifndef PACK_PROT_CONSTS_SVH
`define PACK_PROT_CONSTS_SVH

// Register indexes; byte address is four times the index
`define IDX_CONTROL 4'h0
`define IDX_STATUS 4'h1
`define IDX_LATCH 4'h2
`define IDX_BALANCE 4'h3
`define IDX_TRIM 4'h4
`define IDX_WAKE 4'h5
`define IDX_HOST_TGT 4'h6
`define IDX_STORED_TGT 4'h7
`define IDX_CHG_CFG 4'h8
`define IDX_BUCK 4'h9
`define IDX_LAST 4'h9

// Control register fields
`define CTL_CHG_EN 0
`define CTL_DSG_EN 1
`define CTL_HALT 2
`define CTL_CHGR_EN 3
`define CTL_HOST_PROF 4
`define CTL_W 5

// Status register fields
`define ST_ADAPTER_FET_PERMIT 0
`define ST_FUSE_RAW 1
`define ST_HALTED 2
`define ST_TRIM 3
`define ST_ACGATE 4
`define ST_PHASE_LO 5
`define ST_PHASE_HI 6

// Latched status fields, write one to clear
`define LT_FUSE 0
`define LT_OSC 1
`define LT_SAFETY 2
`define LT_W 3

// Reset values
`define CTL_RESET 5'h00
`define BAL_RESET 3'h0
`define WAKE_RESET 8'h10
`define BUCK_RESET 8'h00

// Timing
`define SYS_CLK_MHZ 250
`define FUSE_DELAY_MS 1
`define FUSE_BLOW_MS 500
`define RST_HOLD_US 2000
`define OSC_NOM_HZ 262144
`define OSC_WINDOW_US 256
`define BUCK_KHZ 1000
`define PRE_CUR_SHIFT 3

`endif

// file: pack_prot_pkg.sv
package pack_prot_pkg;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_PRE = 2'b01,
    PH_CCCV = 2'b10,
    PH_DONE = 2'b11
  } charge_phase_t;
  typedef logic [31:0] word_t;
  typedef logic [15:0] meas_t;
endpackage

// file: level_sync.sv
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic [W-1:0] asyncIn, // Pins from outside the domain
  output logic [W-1:0] syncOut // Resynchronised levels
);
  logic [W-1:0] meta_r;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      syncOut <= '0;
    end
    else
    begin
      meta_r <= asyncIn;
      syncOut <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: slow_osc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module slow_osc_monitor #(
  parameter int unsigned WINDOW_CYC = 64000,
  parameter int unsigned MIN_EDGES = 33
) (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic oscLevel, // Synchronised slow oscillator
  output logic oscFail // One-cycle pulse on a slow window
);
  logic [31:0] winCnt_r, winCnt_nxt;
  logic [31:0] edgeCnt_r, edgeCnt_nxt;
  logic oscPrev_r;
  logic oscFail_nxt;

  // Count rising edges over a fixed window, judge at its end
  always_comb
  begin
    winCnt_nxt = winCnt_r + 32'h1;
    edgeCnt_nxt = edgeCnt_r + {31'h0, (oscLevel & ~oscPrev_r)};
    oscFail_nxt = 1'b0;
    if (winCnt_r == WINDOW_CYC - 1)
    begin
      winCnt_nxt = '0;
      edgeCnt_nxt = '0;
      oscFail_nxt = (edgeCnt_r < MIN_EDGES);
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      winCnt_r <= '0;
      edgeCnt_r <= '0;
      oscPrev_r <= 1'b0;
      oscFail <= 1'b0;
    end
    else
    begin
      winCnt_r <= winCnt_nxt;
      edgeCnt_r <= edgeCnt_nxt;
      oscPrev_r <= oscLevel;
      oscFail <= oscFail_nxt;
    end
  end
endmodule
`default_nettype wire

// file: pack_prot_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module pack_prot_monitor #(
  parameter int unsigned RST_HOLD_CYC = 16
) (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Async reset
  input wire logic hsel, // Bus select
  input wire logic [31:0] haddr, // Bus address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic hready, // Bus ready
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Slave response
  input wire logic safetyFault, // Fault pin
  input wire logic supplyAboveSense, // Adapter compare
  input wire logic regulatorGood, // Regulator good
  input wire logic wakeCompTrip, // Wake comparator
  input wire logic chargeFetGate, // Charge gate
  input wire logic dischargeFetGate, // Discharge gate
  input wire logic adapterFetGate, // Adapter gate
  input wire logic [2:0] balanceEn, // Bypass switches
  input wire logic gaugeResetOut, // Reset hold
  input wire logic halted, // Halt state
  input wire logic frontEndIrq // Interrupt
);
  int unsigned regRun_r;
  int unsigned regRun_nxt;
  logic take;
  logic wrBal;
  logic wrCtl;
  logic rdLatch;

  // Accepted transfers, decoded by byte address
  assign take = hsel && htrans[1] && hready;
  assign wrBal = take && hwrite && haddr == 32'h0000000c;
  assign wrCtl = take && hwrite && haddr == 32'h00000000;
  assign rdLatch = take && !hwrite && haddr == 32'h00000008;

  // Run of good-regulator cycles; raw pin, so it leads the design's synced copy
  always_comb
  begin
    regRun_nxt = regulatorGood ? regRun_r + 1 : 0;
  end
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      regRun_r <= 0;
    else
      regRun_r <= regRun_nxt;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence faultHeld;
    safetyFault [*4];
  endsequence
  sequence supplyLow;
    !supplyAboveSense [*4];
  endsequence
  sequence regLow;
    !regulatorGood [*4];
  endsequence

  safety_gates_a: assert property (faultHeld |-> !chargeFetGate && !dischargeFetGate)
    else $error("gates on during safety fault");
  adapter_low_a: assert property (supplyLow |-> !adapterFetGate)
    else $error("adapter gate on without supply");
  reg_drop_a: assert property (regLow |-> gaugeResetOut)
    else $error("no reset on regulator drop");
  hold_min_a: assert property ($fell(gaugeResetOut) |-> regRun_r >= RST_HOLD_CYC)
    else $error("reset hold too short");
  hold_max_a: assert property (regRun_r == RST_HOLD_CYC + 8 |-> !gaugeResetOut)
    else $error("reset hold too long");
  hold_gates_a: assert property (gaugeResetOut && $past(gaugeResetOut) |->
    !chargeFetGate && !dischargeFetGate && !adapterFetGate)
    else $error("gate on during reset hold");
  balance_write_a: assert property ($changed(balanceEn) |-> $past(wrBal, 2) || $past(wrBal, 3))
    else $error("balance changed without write");
  halt_set_a: assert property ($rose(halted) |-> $past(wrCtl, 2) || $past(wrCtl, 3))
    else $error("halt without control write");
  wake_clear_a: assert property ($fell(halted) |->
    $past(wakeCompTrip, 2) || $past(wakeCompTrip, 3) || $past(wakeCompTrip, 4))
    else $error("halt left without wake");
  irq_clear_a: assert property ($fell(frontEndIrq) |-> $past(rdLatch) || $past(rdLatch, 2))
    else $error("interrupt dropped without read");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus wait or error");
endmodule
bind pack_protection_fet_fuse_ctrl pack_prot_monitor #(.RST_HOLD_CYC(RST_HOLD_CYC)) monitor (
  .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .safetyFault(safetyFault), .supplyAboveSense(supplyAboveSense),
  .regulatorGood(regulatorGood), .wakeCompTrip(wakeCompTrip),
  .chargeFetGate(chargeFetGate), .dischargeFetGate(dischargeFetGate),
  .adapterFetGate(adapterFetGate), .balanceEn(balanceEn),
  .gaugeResetOut(gaugeResetOut), .halted(halted), .frontEndIrq(frontEndIrq)
);
`default_nettype wire

// file: gauge_bus_master.sv
`timescale 1ns/10ps
`default_nettype none
module gauge_bus_master (
  input wire logic sys_clk, // Clock
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  output logic hsel, // Select
  output logic [31:0] haddr, // Address
  output logic [1:0] htrans, // Transfer type
  output logic hwrite, // Write
  output logic [2:0] hsize, // Word size
  output logic [31:0] hwdata // Write data
);
  // Bus idle at time zero
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One single word transfer; caller enters just after a rising edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    q = hrdata;
    // Stale data never lingers on the released lines
    hwdata <= ~d;
  endtask

  // Trim load that must follow every reset release
  task automatic load_trim(input logic [7:0] t);
    logic [31:0] q;
    xfer(1'b1, 32'h10, {24'h0, t}, q);
  endtask
endmodule
`default_nettype wire

// file: pack_protection_fet_fuse_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pack_protection_fet_fuse_ctrl_tb;
  import pack_prot_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize, balanceEn;
  word_t hrdata;
  logic safetyFault = 1'b0;
  logic supplyAboveSense = 1'b0;
  logic fuseDriveRaw = 1'b0;
  logic regulatorGood = 1'b1;
  logic slowOscIn = 1'b0;
  logic wakeCompTrip = 1'b0;
  meas_t cellVoltMin = 16'h0000;
  meas_t cellVoltMax = 16'h0400;
  meas_t chargeCurrent = 16'h0000;
  meas_t chargeVoltSet, chargeCurSet;
  logic chargeFetGate, dischargeFetGate, adapterFetGate, gaugeResetOut, halted;
  logic frontEndIrq, buckHighGate, buckLowGate;
  logic [7:0] wakeThreshold, trimValue;
  logic oscRun = 1'b1;
  int oscCnt = 0;
  int cycles = 0;
  int errCount = 0;
  int checkCount = 0;
  logic [2:0] balPat [4] = '{3'h1, 3'h2, 3'h4, 3'h7};

  always #2 sys_clk = ~sys_clk;

  gauge_bus_master pm (.sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  pack_protection_fet_fuse_ctrl #(.FUSE_DELAY_CYC(20), .FUSE_BLOW_CYC(40), .RST_HOLD_CYC(16),
    .OSC_WINDOW_CYC(200), .OSC_MIN_EDGES(2)) uut (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .safetyFault(safetyFault),
    .supplyAboveSense(supplyAboveSense), .fuseDriveRaw(fuseDriveRaw),
    .regulatorGood(regulatorGood), .slowOscIn(slowOscIn), .wakeCompTrip(wakeCompTrip),
    .cellVoltMin(cellVoltMin), .cellVoltMax(cellVoltMax), .chargeCurrent(chargeCurrent),
    .chargeFetGate(chargeFetGate), .dischargeFetGate(dischargeFetGate),
    .adapterFetGate(adapterFetGate), .balanceEn(balanceEn), .wakeThreshold(wakeThreshold),
    .trimValue(trimValue), .gaugeResetOut(gaugeResetOut), .halted(halted),
    .frontEndIrq(frontEndIrq), .chargeVoltSet(chargeVoltSet), .chargeCurSet(chargeCurSet),
    .buckHighGate(buckHighGate), .buckLowGate(buckLowGate));

  // Slow oscillator stand-in: 5 rising edges per window while running
  always @(posedge sys_clk)
  begin
    oscCnt <= oscCnt + 1;
    if (oscRun && oscCnt % 20 == 0)
      slowOscIn <= ~slowOscIn;
  end

  // Hang guard, well above the expected run length
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      errCount++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (errCount == 0 && checkCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      errCount++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    pm.xfer(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    pm.xfer(1'b1, a, d, q);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Main sequence
  initial
  begin
    tick(10);
    rst <= 1'b0;
    tick(8);
    chk(gaugeResetOut, 1'b1);
    for (int i = 0; i < 40 && gaugeResetOut !== 1'b0; i++) tick(1);
    chk(gaugeResetOut, 1'b0);
    wr(32'h0, 32'h3);
    tick(3);
    chk({chargeFetGate, dischargeFetGate}, 2'b00);
    rdchk(32'h40, 32'hffffffff, 32'h0);
    pm.load_trim(8'h5a);
    tick(3);
    chk(trimValue, 8'h5a);
    chk({chargeFetGate, dischargeFetGate}, 2'b11);
    rdchk(32'h4, 32'h8, 32'h8);
    wr(32'h0, 32'h0);
    tick(2);
    chk({chargeFetGate, dischargeFetGate}, 2'b00);
    wr(32'h0, 32'h3);
    rdchk(32'h8, 32'h7, 32'h0);
    safetyFault <= 1'b1;
    tick(5);
    chk({chargeFetGate, dischargeFetGate}, 2'b00);
    chk(frontEndIrq, 1'b1);
    safetyFault <= 1'b0;
    rdchk(32'h8, 32'h7, 32'h4);
    tick(1);
    chk(frontEndIrq, 1'b0);
    wr(32'h8, 32'h7);
    rdchk(32'h8, 32'h7, 32'h0);
    wr(32'h4, 32'h1);
    supplyAboveSense <= 1'b1;
    tick(5);
    chk(adapterFetGate, 1'b1);
    rdchk(32'h4, 32'h11, 32'h11);
    supplyAboveSense <= 1'b0;
    tick(5);
    chk(adapterFetGate, 1'b0);
    supplyAboveSense <= 1'b1;
    wr(32'h4, 32'h0);
    tick(5);
    chk(adapterFetGate, 1'b0);
    foreach (balPat[i])
    begin
      wr(32'hc, {29'h0, balPat[i]});
      tick(2);
      chk(balanceEn, balPat[i]);
    end
    rdchk(32'hc, 32'h7, 32'h7);
    wr(32'h14, 32'h33);
    tick(2);
    chk(wakeThreshold, 8'h33);
    wr(32'h0, 32'h7);
    tick(2);
    chk(halted, 1'b1);
    wakeCompTrip <= 1'b1;
    tick(5);
    chk(halted, 1'b0);
    wakeCompTrip <= 1'b0;
    cellVoltMin <= 16'h1000;
    chargeCurrent <= 16'h0100;
    wr(32'h20, 32'h00102000);
    wr(32'h18, 32'h01230456);
    wr(32'h0, 32'h1b);
    tick(4);
    chk(chargeVoltSet, 16'h0456);
    chk(chargeCurSet, 16'h0024);
    rdchk(32'h4, 32'h60, 32'h20);
    cellVoltMin <= 16'h3000;
    tick(4);
    chk(chargeCurSet, 16'h0123);
    rdchk(32'h4, 32'h60, 32'h40);
    wr(32'h24, 32'hfa);
    tick(2);
    chk({buckHighGate, buckLowGate}, 2'b10);
    chargeCurrent <= 16'h0008;
    tick(4);
    rdchk(32'h4, 32'h60, 32'h40);
    cellVoltMax <= 16'h0456;
    tick(4);
    rdchk(32'h4, 32'h60, 32'h60);
    chk({buckHighGate, buckLowGate}, 2'b00);
    oscRun <= 1'b0;
    tick(500);
    rdchk(32'h8, 32'h2, 32'h2);
    wr(32'h8, 32'h7);
    fuseDriveRaw <= 1'b1;
    tick(6);
    rdchk(32'h4, 32'h2, 32'h2);
    tick(6);
    fuseDriveRaw <= 1'b0;
    tick(3);
    fuseDriveRaw <= 1'b1;
    tick(14);
    rdchk(32'h8, 32'h1, 32'h0);
    tick(10);
    rdchk(32'h8, 32'h1, 32'h1);
    fuseDriveRaw <= 1'b0;
    wr(32'h8, 32'h1);
    tick(60);
    chk({chargeFetGate, dischargeFetGate}, 2'b11);
    fuseDriveRaw <= 1'b1;
    tick(30);
    chk({chargeFetGate, dischargeFetGate}, 2'b11);
    tick(45);
    chk({chargeFetGate, dischargeFetGate}, 2'b00);
    fuseDriveRaw <= 1'b0;
    regulatorGood <= 1'b0;
    tick(6);
    chk(gaugeResetOut, 1'b1);
    regulatorGood <= 1'b1;
    for (int i = 0; i < 40 && gaugeResetOut !== 1'b0; i++) tick(1);
    chk(gaugeResetOut, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
